// ===== core/rifpm_top.v
// Flag registers, receive timers, clock output divider and event pin routing.
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "rifpm_map.vh"
module rifpm_top (
  input  wire        CLK_SYS,
  input  wire        RESETN,
  input  wire [7:0]  S_AXI_AWADDR,
  input  wire        S_AXI_AWVALID,
  output wire        S_AXI_AWREADY,
  input  wire [31:0] S_AXI_WDATA,
  input  wire [3:0]  S_AXI_WSTRB,
  input  wire        S_AXI_WVALID,
  output wire        S_AXI_WREADY,
  output wire [1:0]  S_AXI_BRESP,
  output wire        S_AXI_BVALID,
  input  wire        S_AXI_BREADY,
  input  wire [7:0]  S_AXI_ARADDR,
  input  wire        S_AXI_ARVALID,
  output wire        S_AXI_ARREADY,
  output wire [31:0] S_AXI_RDATA,
  output wire [1:0]  S_AXI_RRESP,
  output wire        S_AXI_RVALID,
  input  wire        S_AXI_RREADY,
  input  wire [2:0]  OP_MODE,
  input  wire        PACKET_MODE,
  input  wire        XO_RUNNING,
  input  wire        PLL_LOCKED,
  input  wire        RSSI_SAMPLING,
  input  wire        RX_SETTLED,
  input  wire        PA_RAMP_DONE,
  input  wire        AUTO_MODE_ACTIVE,
  input  wire [7:0]  SIGNAL_LEVEL,
  input  wire        SYNC_DETECT,
  input  wire [6:0]  FIFO_COUNT,
  input  wire        FIFO_OVERRUN,
  input  wire        PACKET_DONE,
  input  wire        PAYLOAD_DONE,
  input  wire        CRC_ON,
  input  wire        CRC_PASS,
  input  wire        CHECKSUM_AUTOCLEAR_DISABLE,
  input  wire        BIT_TICK,
  input  wire        CONT_DATA,
  input  wire        RC_OSC_CLK,
  output wire [5:0]  EVENT_PIN,
  output wire        REF_CLOCK_OUTPUT,
  output wire        RC_OSC_ENABLE,
  output wire        FIFO_CLEAR
);

  // Routes one pin: packet mode and continuous mode each have four sources.
  function rifpm_pin_route;
    input [1:0] code;
    input       pkt;
    input [7:0] src;
    begin
      if (pkt) begin
        rifpm_pin_route = src[code];
      end else begin
        rifpm_pin_route = src[{1'b1, code}];
      end
    end
  endfunction

  // Loads a receive timer with value times sixteen bit periods.
  function [11:0] rifpm_tmo_load;
    input [7:0] value;
    begin
      rifpm_tmo_load = {value, `RIFPM_BITS_PER_UNIT};
    end
  endfunction

  // Bus handshake state.
  reg        aw_ready_reg;
  reg        b_valid_reg;
  reg [1:0]  b_resp_reg;
  reg        ar_ready_reg;
  reg        r_valid_reg;
  reg [1:0]  r_resp_reg;
  reg [31:0] r_data_reg;
  // Configuration registers.
  reg [7:0]  map_low_reg;
  reg [3:0]  map_high_reg;
  reg [2:0]  ref_clock_out_select_reg;
  reg [7:0]  signal_level_threshold_reg;
  reg [7:0]  rx_start_timeout_reg;
  reg [7:0]  rx_payload_timeout_reg;
  reg [6:0]  buffer_level_threshold_reg;
  // Flags.
  reg        mode_reached_flag_reg;
  reg        receive_ready_flag_reg;
  reg        transmit_ready_flag_reg;
  reg        synth_lock_flag_reg;
  reg        signal_flag_reg;
  reg        timeout_flag_reg;
  reg        intermediate_mode_flag_reg;
  reg        sync_match_flag_reg;
  reg        buffer_full_flag_reg;
  reg        buffer_nonempty_flag_reg;
  reg        buffer_level_flag_reg;
  reg        buffer_overrun_flag_reg;
  reg        frame_sent_flag_reg;
  reg        frame_received_flag_reg;
  reg        checksum_good_flag_reg;
  // Mode tracking, timers and outputs.
  reg [2:0]  mode_prev_reg;
  reg        nonempty_prev_reg;
  reg [11:0] start_cnt_reg;
  reg        start_run_reg;
  reg [11:0] pay_cnt_reg;
  reg        pay_run_reg;
  reg [4:0]  div_cnt_reg;
  reg        rc_sync1_reg;
  reg        rc_sync2_reg;
  reg        ref_out_reg;
  reg        rc_en_reg;
  reg        fifo_clear_reg;
  reg [5:0]  pin_reg;

  // Decoded bus accesses.
  wire       wr_fire   = S_AXI_AWVALID & aw_ready_reg;
  wire [5:0] wr_idx    = S_AXI_AWADDR[7:2];
  wire       wr_lane   = S_AXI_WSTRB[0];
  wire [7:0] wd        = S_AXI_WDATA[7:0];
  wire       rd_fire   = S_AXI_ARVALID & ar_ready_reg;
  wire [5:0] rd_idx    = S_AXI_ARADDR[7:2];
  wire       wr_flags1 = wr_fire & wr_lane & (wr_idx == `RIFPM_IDX_FLAGS1);
  wire       wr_flags2 = wr_fire & wr_lane & (wr_idx == `RIFPM_IDX_FLAGS2);

  // Mode conditions.
  wire in_rx       = (OP_MODE == `RIFPM_MODE_RX);
  wire in_tx       = (OP_MODE == `RIFPM_MODE_TX);
  wire in_sleep    = (OP_MODE == `RIFPM_MODE_SLEEP);
  wire mode_change = (OP_MODE != mode_prev_reg);
  wire rx_entry    = in_rx & (mode_prev_reg != `RIFPM_MODE_RX);
  wire fifo_empty  = (FIFO_COUNT == `RIFPM_FIFO_EMPTY);
  wire emptied     = nonempty_prev_reg & fifo_empty;

  reg mode_ok;
  // Readiness of the requested operating mode.
  always @* begin
    case (OP_MODE)
      `RIFPM_MODE_SLEEP: mode_ok = 1'b1;
      `RIFPM_MODE_STBY:  mode_ok = XO_RUNNING;
      `RIFPM_MODE_FS:    mode_ok = PLL_LOCKED;
      `RIFPM_MODE_RX:    mode_ok = RSSI_SAMPLING;
      `RIFPM_MODE_TX:    mode_ok = PA_RAMP_DONE;
      default:           mode_ok = 1'b0;
    endcase
  end

  // Signal level above threshold means a smaller magnitude in half-dB steps.
  wire sig_set   = in_rx & RSSI_SAMPLING & (SIGNAL_LEVEL < signal_level_threshold_reg);
  wire sig_event = sig_set & ~signal_flag_reg;
  wire crc_gate  = ~CRC_ON | CHECKSUM_AUTOCLEAR_DISABLE | CRC_PASS;
  wire pay_set   = in_rx & PAYLOAD_DONE & crc_gate;
  wire start_exp = start_run_reg & BIT_TICK & (start_cnt_reg == 12'h001);
  wire pay_exp   = pay_run_reg & BIT_TICK & (pay_cnt_reg == 12'h001);

  // Register reads show configuration and live flag state.
  reg [7:0] rd_val;
  reg       rd_hit;
  always @* begin
    rd_val = 8'h00;
    rd_hit = 1'b1;
    case (rd_idx)
      `RIFPM_IDX_MAP_LOW:   rd_val = map_low_reg;
      `RIFPM_IDX_MAP_HIGH:  rd_val = {map_high_reg, 1'b0, ref_clock_out_select_reg};
      `RIFPM_IDX_FLAGS1:    rd_val = {mode_reached_flag_reg, receive_ready_flag_reg,
                                      transmit_ready_flag_reg, synth_lock_flag_reg,
                                      signal_flag_reg, timeout_flag_reg,
                                      intermediate_mode_flag_reg, sync_match_flag_reg};
      `RIFPM_IDX_FLAGS2:    rd_val = {buffer_full_flag_reg, buffer_nonempty_flag_reg,
                                      buffer_level_flag_reg, buffer_overrun_flag_reg,
                                      frame_sent_flag_reg, frame_received_flag_reg,
                                      checksum_good_flag_reg, 1'b0};
      `RIFPM_IDX_THRESH:    rd_val = signal_level_threshold_reg;
      `RIFPM_IDX_TMO_START: rd_val = rx_start_timeout_reg;
      `RIFPM_IDX_TMO_PAY:   rd_val = rx_payload_timeout_reg;
      `RIFPM_IDX_LVL_THR:   rd_val = {1'b0, buffer_level_threshold_reg};
      default:              rd_hit = 1'b0;
    endcase
  end

  // Write channel: address and data are taken together, one write at a time.
  always @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      aw_ready_reg <= 1'b0;
      b_valid_reg  <= 1'b0;
      b_resp_reg   <= `RIFPM_RESP_OKAY;
    end else begin
      aw_ready_reg <= S_AXI_AWVALID & S_AXI_WVALID & ~aw_ready_reg & ~b_valid_reg;
      if (wr_fire) begin
        b_valid_reg <= 1'b1;
        case (wr_idx)
          `RIFPM_IDX_MAP_LOW, `RIFPM_IDX_MAP_HIGH, `RIFPM_IDX_FLAGS1,
          `RIFPM_IDX_FLAGS2, `RIFPM_IDX_THRESH, `RIFPM_IDX_TMO_START,
          `RIFPM_IDX_TMO_PAY, `RIFPM_IDX_LVL_THR: b_resp_reg <= `RIFPM_RESP_OKAY;
          default: b_resp_reg <= `RIFPM_RESP_DECERR;
        endcase
      end else if (S_AXI_BREADY) begin
        b_valid_reg <= 1'b0;
      end
    end
  end

  // Read channel: data is captured on the address handshake.
  always @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      ar_ready_reg <= 1'b0;
      r_valid_reg  <= 1'b0;
      r_resp_reg   <= `RIFPM_RESP_OKAY;
      r_data_reg   <= 32'h00000000;
    end else begin
      ar_ready_reg <= S_AXI_ARVALID & ~ar_ready_reg & ~r_valid_reg;
      if (rd_fire) begin
        r_valid_reg <= 1'b1;
        r_data_reg  <= {24'h000000, rd_val};
        r_resp_reg  <= rd_hit ? `RIFPM_RESP_OKAY : `RIFPM_RESP_DECERR;
      end else if (S_AXI_RREADY) begin
        r_valid_reg <= 1'b0;
      end
    end
  end

  // Configuration registers written by software.
  always @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      map_low_reg                <= `RIFPM_RST_MAP;
      map_high_reg               <= 4'h0;
      ref_clock_out_select_reg   <= `RIFPM_RST_REF_CLOCK_OUTPUT;
      signal_level_threshold_reg <= `RIFPM_RST_THRESH;
      rx_start_timeout_reg       <= `RIFPM_RST_TMO;
      rx_payload_timeout_reg     <= `RIFPM_RST_TMO;
      buffer_level_threshold_reg <= `RIFPM_RST_LVL_THR;
    end else if (wr_fire & wr_lane) begin
      case (wr_idx)
        `RIFPM_IDX_MAP_LOW: map_low_reg <= wd;
        `RIFPM_IDX_MAP_HIGH: begin
          map_high_reg             <= wd[7:4];
          ref_clock_out_select_reg <= wd[2:0];
        end
        `RIFPM_IDX_THRESH:    signal_level_threshold_reg <= wd;
        `RIFPM_IDX_TMO_START: rx_start_timeout_reg <= wd;
        `RIFPM_IDX_TMO_PAY:   rx_payload_timeout_reg <= wd;
        `RIFPM_IDX_LVL_THR:   buffer_level_threshold_reg <= wd[6:0];
        default: ;
      endcase
    end
  end

  // Mode-related flags; a mode change drops readiness until reached again.
  always @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      mode_prev_reg              <= `RIFPM_MODE_SLEEP;
      mode_reached_flag_reg      <= 1'b1;
      receive_ready_flag_reg     <= 1'b0;
      transmit_ready_flag_reg    <= 1'b0;
      synth_lock_flag_reg        <= 1'b0;
      intermediate_mode_flag_reg <= 1'b0;
      nonempty_prev_reg          <= 1'b0;
    end else begin
      mode_prev_reg <= OP_MODE;
      if (mode_change) begin
        mode_reached_flag_reg <= 1'b0;
      end else if (mode_ok) begin
        mode_reached_flag_reg <= 1'b1;
      end
      receive_ready_flag_reg     <= in_rx & (receive_ready_flag_reg | RX_SETTLED);
      transmit_ready_flag_reg    <= in_tx & (transmit_ready_flag_reg | PA_RAMP_DONE);
      synth_lock_flag_reg        <= PLL_LOCKED & (in_rx | in_tx |
                                    (OP_MODE == `RIFPM_MODE_FS));
      intermediate_mode_flag_reg <= AUTO_MODE_ACTIVE;
      nonempty_prev_reg          <= ~fifo_empty;
    end
  end

  // Event flags; a hardware set in the same cycle as a clear wins.
  always @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      signal_flag_reg         <= 1'b0;
      timeout_flag_reg        <= 1'b0;
      sync_match_flag_reg     <= 1'b0;
      buffer_overrun_flag_reg <= 1'b0;
      frame_sent_flag_reg     <= 1'b0;
      frame_received_flag_reg <= 1'b0;
      checksum_good_flag_reg  <= 1'b0;
    end else begin
      if (sig_set) begin
        signal_flag_reg <= 1'b1;
      end else if (~in_rx | (wr_flags1 & wd[`RIFPM_F1_SIG])) begin
        signal_flag_reg <= 1'b0;
      end
      if (start_exp | pay_exp) begin
        timeout_flag_reg <= 1'b1;
      end else if (~in_rx | emptied) begin
        timeout_flag_reg <= 1'b0;
      end
      if (in_rx & SYNC_DETECT) begin
        sync_match_flag_reg <= 1'b1;
      end else if (~in_rx | emptied |
                   (~PACKET_MODE & wr_flags1 & wd[`RIFPM_F1_SYNC])) begin
        sync_match_flag_reg <= 1'b0;
      end
      if (FIFO_OVERRUN & ~in_sleep) begin
        buffer_overrun_flag_reg <= 1'b1;
      end else if (wr_flags2 & wd[`RIFPM_F2_OVR]) begin
        buffer_overrun_flag_reg <= 1'b0;
      end
      if (in_tx & PACKET_DONE) begin
        frame_sent_flag_reg <= 1'b1;
      end else if (~in_tx) begin
        frame_sent_flag_reg <= 1'b0;
      end
      if (pay_set) begin
        frame_received_flag_reg <= 1'b1;
      end else if (fifo_empty) begin
        frame_received_flag_reg <= 1'b0;
      end
      if (in_rx & PAYLOAD_DONE & CRC_PASS) begin
        checksum_good_flag_reg <= 1'b1;
      end else if (fifo_empty) begin
        checksum_good_flag_reg <= 1'b0;
      end
    end
  end

  // FIFO occupancy flags and the clear pulse sent to the FIFO.
  always @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      buffer_full_flag_reg     <= 1'b0;
      buffer_nonempty_flag_reg <= 1'b0;
      buffer_level_flag_reg    <= 1'b0;
      fifo_clear_reg           <= 1'b0;
    end else begin
      buffer_full_flag_reg     <= (FIFO_COUNT == `RIFPM_FIFO_FULL);
      buffer_nonempty_flag_reg <= ~fifo_empty;
      buffer_level_flag_reg    <= (FIFO_COUNT > buffer_level_threshold_reg);
      fifo_clear_reg           <= wr_flags2 & wd[`RIFPM_F2_OVR];
    end
  end

  // Start timer runs from receive entry until a signal event or expiry.
  always @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      start_cnt_reg <= 12'h000;
      start_run_reg <= 1'b0;
    end else if (~in_rx | sig_event | start_exp) begin
      start_run_reg <= 1'b0;
    end else if (rx_entry) begin
      start_cnt_reg <= rifpm_tmo_load(rx_start_timeout_reg);
      start_run_reg <= (rx_start_timeout_reg != `RIFPM_RST_TMO);
    end else if (start_run_reg & BIT_TICK) begin
      start_cnt_reg <= start_cnt_reg - 12'h001;
    end
  end

  // Payload timer runs from a signal event until a frame arrives or expiry.
  always @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      pay_cnt_reg <= 12'h000;
      pay_run_reg <= 1'b0;
    end else if (~in_rx | pay_set | pay_exp) begin
      pay_run_reg <= 1'b0;
    end else if (sig_event) begin
      pay_cnt_reg <= rifpm_tmo_load(rx_payload_timeout_reg);
      pay_run_reg <= (rx_payload_timeout_reg != `RIFPM_RST_TMO);
    end else if (pay_run_reg & BIT_TICK) begin
      pay_cnt_reg <= pay_cnt_reg - 12'h001;
    end
  end

  // Clock output: divided crystal as enable pulses, RC oscillator, or off.
  wire [4:0] div_mask = (5'h01 << ref_clock_out_select_reg) - 5'h01;
  always @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      div_cnt_reg  <= 5'h00;
      rc_sync1_reg <= 1'b0;
      rc_sync2_reg <= 1'b0;
      ref_out_reg  <= 1'b0;
      rc_en_reg    <= 1'b0;
    end else begin
      div_cnt_reg  <= div_cnt_reg + 5'h01;
      rc_sync1_reg <= RC_OSC_CLK;
      rc_sync2_reg <= rc_sync1_reg;
      rc_en_reg    <= (ref_clock_out_select_reg == `RIFPM_CLK_RC);
      case (ref_clock_out_select_reg)
        `RIFPM_CLK_RC:  ref_out_reg <= rc_sync2_reg;
        `RIFPM_CLK_OFF: ref_out_reg <= 1'b0;
        default:        ref_out_reg <= ((div_cnt_reg & div_mask) == 5'h00);
      endcase
    end
  end

  // Event pins: packet sources in slots 0-3, continuous sources in slots 4-7.
  wire [7:0]  pin_src = {timeout_flag_reg, signal_flag_reg, CONT_DATA, sync_match_flag_reg,
                         mode_reached_flag_reg, sync_match_flag_reg, buffer_level_flag_reg,
                         in_tx ? frame_sent_flag_reg : frame_received_flag_reg};
  wire [11:0] pin_map = {map_low_reg, map_high_reg};
  integer i;
  always @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      pin_reg <= 6'h00;
    end else begin
      for (i = 0; i < 6; i = i + 1) begin
        pin_reg[i] <= rifpm_pin_route(pin_map[11 - 2 * i -: 2], PACKET_MODE, pin_src);
      end
    end
  end

  assign S_AXI_AWREADY    = aw_ready_reg;
  assign S_AXI_WREADY     = aw_ready_reg;
  assign S_AXI_BVALID     = b_valid_reg;
  assign S_AXI_BRESP      = b_resp_reg;
  assign S_AXI_ARREADY    = ar_ready_reg;
  assign S_AXI_RVALID     = r_valid_reg;
  assign S_AXI_RRESP      = r_resp_reg;
  assign S_AXI_RDATA      = r_data_reg;
  assign EVENT_PIN        = pin_reg;
  assign REF_CLOCK_OUTPUT = ref_out_reg;
  assign RC_OSC_ENABLE    = rc_en_reg;
  assign FIFO_CLEAR       = fifo_clear_reg;

endmodule

// ===== core/rifpm_map.vh
// Register map, field positions and constants for the radio flag and pin mapping block.
// What this block does
// - Six 2-bit pin select fields, pin 0 in top bits of first register, reset zero.
// - Clock output code picks crystal divided 1..32, RC oscillator, or off.
// - Mode-reached flag sets when requested mode is ready; resets to one.
// - Mode-reached flag clears on any mode change request until ready again.
// - Receive-ready flag sets in receive after settling; clears leaving receive.
// - Transmit-ready flag sets after amplifier ramp-up; clears leaving transmit.
// - Synth lock flag follows lock state in synth, receive or transmit.
// - Signal flag sets in receive above threshold; clears leaving receive or host write.
// - Timeout flag sets on either timer expiry; clears leaving receive or FIFO emptied.
// - Intermediate mode flag is high while in the automatic intermediate mode.
// - Sync flag sets on sync match; clears leaving receive, emptied; continuous host-clearable.
// - Buffer full flag high exactly while FIFO holds 66 bytes.
// - Buffer non-empty flag high while FIFO holds one or more bytes.
// - Buffer level flag high while byte count strictly exceeds the threshold.
// - Overrun flag sets on FIFO overrun in any mode except sleep.
// - Host writing one to overrun clears the FIFO and flag at once.
// - Frame-sent flag sets in transmit after full packet; clears leaving transmit.
// - Frame-received flag sets after last byte, CRC gated if enabled; clears when empty.
// - Checksum-good flag sets in receive on CRC pass; clears when FIFO empty.
// - Start timer raises timeout if no signal event in value times 16 bits.
// - Payload timer raises timeout if no frame after signal event; zero disables.
// - Signal threshold encodes minus value over two dBm; reset 0xE4.
// - Measured level is an unsigned half-dB magnitude compared against the threshold.
// - Buffer level threshold is a 7-bit field resetting to 0001111.
`ifndef RIFPM_MAP_VH
`define RIFPM_MAP_VH
// Register indexes; byte address is four times the index.
`define RIFPM_IDX_MAP_LOW    6'h25
`define RIFPM_IDX_MAP_HIGH   6'h26
`define RIFPM_IDX_FLAGS1     6'h27
`define RIFPM_IDX_FLAGS2     6'h28
`define RIFPM_IDX_THRESH     6'h29
`define RIFPM_IDX_TMO_START  6'h2A
`define RIFPM_IDX_TMO_PAY    6'h2B
`define RIFPM_IDX_LVL_THR    6'h3C
// Reset values.
`define RIFPM_RST_MAP        8'h00
`define RIFPM_RST_REF_CLOCK_OUTPUT     3'h7
`define RIFPM_RST_THRESH     8'hE4
`define RIFPM_RST_TMO        8'h00
`define RIFPM_RST_LVL_THR    7'h0F
// Field positions of the flag registers.
`define RIFPM_F1_MODE        7
`define RIFPM_F1_RXRDY       6
`define RIFPM_F1_TXRDY       5
`define RIFPM_F1_LOCK        4
`define RIFPM_F1_SIG         3
`define RIFPM_F1_TMO         2
`define RIFPM_F1_AUTO        1
`define RIFPM_F1_SYNC        0
`define RIFPM_F2_OVR         4
// Operating mode codes.
`define RIFPM_MODE_SLEEP     3'h0
`define RIFPM_MODE_STBY      3'h1
`define RIFPM_MODE_FS        3'h2
`define RIFPM_MODE_TX        3'h3
`define RIFPM_MODE_RX        3'h4
// Clock output codes and FIFO figures.
`define RIFPM_CLK_RC         3'h6
`define RIFPM_CLK_OFF        3'h7
`define RIFPM_FIFO_FULL      7'h42
`define RIFPM_FIFO_EMPTY     7'h00
`define RIFPM_BITS_PER_UNIT  4'h0
// Bus answers.
`define RIFPM_RESP_OKAY      2'h0
`define RIFPM_RESP_DECERR    2'h3
`endif

// ===== tb/rifpm_checker.sv
// Port-level timing checks for the flag and pin mapping block.
`timescale 1ns/1ps
module rifpm_checker (
  input wire logic        CLK_SYS,
  input wire logic        RESETN,
  input wire logic [7:0]  S_AXI_AWADDR,
  input wire logic        S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0]  S_AXI_WSTRB,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic [1:0]  S_AXI_BRESP,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0]  S_AXI_RRESP,
  input wire logic        RC_OSC_CLK,
  input wire logic        RC_OSC_ENABLE,
  input wire logic        REF_CLOCK_OUTPUT,
  input wire logic        FIFO_CLEAR
);
  // A write of one to the overrun bit of the FIFO flag register, seen as it is taken.
  wire ovr_wr = S_AXI_AWREADY && S_AXI_AWADDR == 8'hA0 && S_AXI_WDATA[4] && S_AXI_WSTRB[0];
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);
  a_clear_pulse: assert property (FIFO_CLEAR |=> !FIFO_CLEAR)
    else $error("FIFO clear lasted more than one cycle");
  a_clear_follow: assert property (ovr_wr |-> ##[1:2] FIFO_CLEAR)
    else $error("Overrun write gave no FIFO clear");
  a_clear_cause: assert property (FIFO_CLEAR |-> $past(ovr_wr) || $past(ovr_wr, 2))
    else $error("FIFO clear without overrun write");
  a_rdata_pad: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h0)
    else $error("Read data upper bits not zero");
  a_decerr_zero: assert property (S_AXI_RVALID && S_AXI_RRESP == 2'h3 |-> S_AXI_RDATA == 32'h0)
    else $error("Unmapped read returned data");
  a_bresp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("Write response dropped early");
  a_rdata_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("Read data dropped early");
  a_rc_follow: assert property (RC_OSC_ENABLE && $past(RC_OSC_ENABLE, 4) |-> REF_CLOCK_OUTPUT == $past(RC_OSC_CLK, 3))
    else $error("Clock output does not follow RC oscillator");
endmodule
bind rifpm_top rifpm_checker u_chk (.*);

// ===== tb/rifpm_fifo_model.sv
// Behavioural FIFO fill level that the block watches and can empty.
`timescale 1ns/1ps
module rifpm_fifo_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       clear,
  input  wire logic       load_en,
  input  wire logic [6:0] load_val,
  output wire logic [6:0] count
);
  logic [6:0] count_reg;
  // A clear request empties the FIFO at once, ahead of any new fill level.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) count_reg <= 7'h00;
    else if (clear) count_reg <= 7'h00;
    else if (load_en) count_reg <= load_val;
  end
  assign count = count_reg;
endmodule

// ===== tb/tb.sv
// Self-checking bench for the flag and pin mapping block.
`timescale 1ns/1ps
module tb;
  logic        clk = 0, rstn = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  logic        pkt = 1, xo = 1, lock = 0, rssi_s = 0, rx_set = 0, pa = 0, auto_m = 0;
  logic        sync = 0, ovr = 0, pdone = 0, tick = 0, rc = 0, ld_en = 0;
  logic [7:0]  awaddr = 0, araddr = 0, sig = 8'hFF;
  logic [31:0] wdata = 0;
  logic [3:0]  strb = 4'hF;
  logic [2:0]  op = 0;
  logic [6:0]  ld_val = 0;
  logic        awready, wready, bvalid, arready, rvalid, refo, rce, fclr;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [5:0]  evp;
  logic [6:0]  fcnt;
  int          fails = 0, tests_run = 0;
  rifpm_top uut (.CLK_SYS(clk), .RESETN(rstn), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(strb), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .OP_MODE(op),
    .PACKET_MODE(pkt), .XO_RUNNING(xo), .PLL_LOCKED(lock), .RSSI_SAMPLING(rssi_s),
    .RX_SETTLED(rx_set), .PA_RAMP_DONE(pa), .AUTO_MODE_ACTIVE(auto_m), .SIGNAL_LEVEL(sig),
    .SYNC_DETECT(sync), .FIFO_COUNT(fcnt), .FIFO_OVERRUN(ovr), .PACKET_DONE(pdone),
    .PAYLOAD_DONE(1'b0), .CRC_ON(1'b0), .CRC_PASS(1'b0), .CHECKSUM_AUTOCLEAR_DISABLE(1'b0),
    .BIT_TICK(tick), .CONT_DATA(1'b0), .RC_OSC_CLK(rc), .EVENT_PIN(evp),
    .REF_CLOCK_OUTPUT(refo), .RC_OSC_ENABLE(rce), .FIFO_CLEAR(fclr));
  rifpm_fifo_model u_fifo (.clk(clk), .rst_n(rstn), .clear(fclr), .load_en(ld_en),
    .load_val(ld_val), .count(fcnt));
  // System clock, a bit tick every other cycle and an RC oscillator moving on falling edges.
  initial begin
    forever #2 clk = ~clk;
  end
  always @(posedge clk) tick <= ~tick;
  always #4 rc = ~rc;
  task end_sim;
    $display("Checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h got %h", n, e, g);
    end
  endtask
  // Waits a bounded time for a handshake edge: 0 awready, 1 bvalid, 2 arready, 3 rvalid.
  task wt(input int s);
    int i;
    for (i = 0; i < 64; i++) begin
      @(posedge clk);
      if ((s == 0 ? awready : s == 1 ? bvalid : s == 2 ? arready : rvalid) === 1'b1) break;
    end
    if (i >= 64) begin
      fails++;
      $display("Error handshake expected 1 got 0");
      end_sim;
    end
  endtask
  // Bus write: address and data offered together, response accepted at once.
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    wt(0);
    awv <= 1'b0;
    wv <= 1'b0;
    wt(1);
    bready <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    wt(2);
    arv <= 1'b0;
    wt(3);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task rc8(input logic [7:0] a, input logic [7:0] e, input string n);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(n, {24'h0, e}, d);
  endtask
  task ld(input logic [6:0] v);
    @(posedge clk);
    ld_val <= v;
    ld_en <= 1'b1;
    @(posedge clk);
    ld_en <= 1'b0;
  endtask
  // Reset values of every register except the FIFO flag register, and an unmapped read.
  task t_reset;
    logic [31:0] d;
    logic [1:0]  r;
    rc8(8'h94, 8'h00, "map_low");
    rc8(8'h98, 8'h07, "map_high");
    rc8(8'h9C, 8'h80, "flags1");
    rc8(8'hA4, 8'hE4, "threshold");
    rc8(8'hA8, 8'h00, "start_tmo");
    rc8(8'hAC, 8'h00, "pay_tmo");
    rc8(8'hF0, 8'h0F, "level_thr");
    rd(8'h80, d, r);
    chk("unmapped_resp", 32'h3, {30'h0, r});
    $display("Reset test done");
  endtask
  // Mode changes through synth and transmit and back to standby.
  task t_modes;
    op <= 3'h2;
    rc8(8'h9C, 8'h00, "flags1");
    lock <= 1'b1;
    rc8(8'h9C, 8'h90, "flags1");
    lock <= 1'b0;
    rc8(8'h9C, 8'h80, "flags1");
    op <= 3'h3;
    pa <= 1'b1;
    lock <= 1'b1;
    auto_m <= 1'b1;
    pdone <= 1'b1;
    @(posedge clk);
    pdone <= 1'b0;
    rc8(8'h9C, 8'hB2, "flags1");
    rc8(8'hA0, 8'h08, "flags2");
    op <= 3'h1;
    pa <= 1'b0;
    lock <= 1'b0;
    auto_m <= 1'b0;
    rc8(8'h9C, 8'h80, "flags1");
    rc8(8'hA0, 8'h00, "flags2");
    $display("Mode test done");
  endtask
  // FIFO levels: full, at threshold, above threshold, empty.
  task t_fifo;
    logic [6:0] cn[4] = '{7'd66, 7'd15, 7'd16, 7'd0};
    logic [7:0] ex[4] = '{8'hE0, 8'h40, 8'h60, 8'h00};
    for (int k = 0; k < 4; k++) begin
      ld(cn[k]);
      rc8(8'hA0, ex[k], "flags2");
    end
    $display("FIFO test done");
  endtask
  // Overrun, ignored writes, then a clearing write that empties the FIFO.
  task t_ovr;
    ld(7'd10);
    ovr <= 1'b1;
    @(posedge clk);
    ovr <= 1'b0;
    rc8(8'hA0, 8'h50, "flags2");
    wr(8'hA0, 8'h00);
    strb <= 4'h0;
    wr(8'hA0, 8'h10);
    strb <= 4'hF;
    rc8(8'hA0, 8'h50, "flags2");
    wr(8'hA0, 8'h10);
    rc8(8'hA0, 8'h00, "flags2");
    chk("fifo_count", 32'h0, {25'h0, fcnt});
    $display("Overrun test done");
  endtask
  // Receive: start timeout, signal and sync flags, host clears, leaving receive.
  task t_rx;
    wr(8'hA8, 8'h01);
    op <= 3'h4;
    rssi_s <= 1'b1;
    rx_set <= 1'b1;
    rc8(8'h9C, 8'hC0, "flags1");
    repeat (40) @(posedge clk);
    rc8(8'h9C, 8'hC4, "flags1");
    sig <= 8'h10;
    sync <= 1'b1;
    @(posedge clk);
    sync <= 1'b0;
    rc8(8'h9C, 8'hCD, "flags1");
    rssi_s <= 1'b0;
    wr(8'h9C, 8'h09);
    rc8(8'h9C, 8'hC5, "flags1");
    op <= 3'h1;
    rx_set <= 1'b0;
    rc8(8'h9C, 8'h80, "flags1");
    $display("Receive test done");
  endtask
  // Pin routing and clock output selection.
  task t_pins;
    wr(8'h94, 8'hFF);
    wr(8'h98, 8'hFE);
    repeat (2) @(posedge clk);
    chk("event_pins", 32'h3F, {26'h0, evp});
    chk("rc_enable", 32'h1, {31'h0, rce});
    rc8(8'h98, 8'hF6, "map_high");
    repeat (20) @(posedge clk);
    wr(8'h98, 8'hF7);
    repeat (2) @(posedge clk);
    chk("clk_off", 32'h0, {30'h0, rce, refo});
    wr(8'h98, 8'hF0);
    repeat (2) @(posedge clk);
    chk("clk_div1", 32'h1, {31'h0, refo});
    $display("Pin test done");
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    t_reset;
    t_modes;
    t_fifo;
    t_ovr;
    t_rx;
    t_pins;
    end_sim;
  end
endmodule
